/* File: pkg/dyn_ctrl_defs.svh */
// register map, field layout, reset values and gain-law constants
// of the dynamics controller; definitions only
`ifndef DYN_CTRL_DEFS_SVH
`define DYN_CTRL_DEFS_SVH
`define ADDR_W 12
`define DATA_W 16
`define SAMPLE_W 24
`define QDB_W 10
`define OFS_CTRL 12'h540
`define OFS_BOOST 12'h541
`define OFS_GATE_SLOPE 12'h542
`define OFS_KNEE 12'h543
`define OFS_GATE_KNEE 12'h544
`define GATE_EN_BIT 8
`define GKO_EN_BIT 5
`define BOOST_LSB 0
`define BOOST_W 2
`define GMIN_LSB 12
`define GMIN_W 4
`define EXP_LSB 10
`define EXP_W 2
`define QRT_LSB 8
`define QRT_W 2
`define QRD_LSB 6
`define QRD_W 2
`define HI_LSB 3
`define HI_W 3
`define LO_LSB 0
`define LO_W 3
`define KIN_LSB 5
`define KIN_W 6
`define KOUT_LSB 0
`define KOUT_W 5
`define GKIN_LSB 5
`define GKIN_W 5
`define GKOUT_LSB 0
`define GKOUT_W 5
`define BOOST_RST 2'h1
`define GMIN_MAX 4'hc
`define QRD_MAX 2'h2
`define HI_MAX 3'h5
`define LO_MAX 3'h4
`define KIN_MAX 6'h3c
`define KOUT_MAX 5'h1e
`define HI_ZERO 3'h5
`define LO_ZERO 3'h4
// gain figures in quarter-dB units
`define BOOST_Q0 48
`define BOOST_Q1 72
`define BOOST_Q2 96
`define BOOST_Q3 144
`define GMIN_BASE -144
`define GMIN_STEP 24
`define QRT_BASE 48
`define QRT_STEP 24
`define KNEE_STEP -3
`define GKIN_BASE -144
`define GKOUT_BASE -120
`define GKNEE_STEP -6
// quick-release decay per 6dB, in microseconds
`define QRD_US0 725
`define QRD_US1 1450
`define QRD_US2 5800
`define QRD_US_W 13
`endif

/* File: pkg/dyn_ctrl_pkg.sv */
// types shared by the dynamics controller modules
// assumes the defs header is on the include path
`include "dyn_ctrl_defs.svh"
package dyn_ctrl_pkg;
  typedef logic signed [`QDB_W-1:0] qdb_t;
  typedef struct packed {
    qdb_t max_boost;
    qdb_t gate_min;
    logic [`EXP_W-1:0] expand_shift;
    qdb_t qr_thresh;
    logic [`QRD_US_W-1:0] qr_decay_us;
    logic [`HI_W-1:0] upper_shift;
    logic upper_zero;
    logic [`LO_W-1:0] lower_shift;
    logic lower_zero;
    qdb_t knee_in;
    qdb_t knee_out;
    qdb_t gate_knee_in;
    logic gate_knee_in_use;
    qdb_t gate_knee_out;
    logic gate_knee_out_use;
  } params_t;
  typedef struct packed {
    logic [`SAMPLE_W-1:0] sample;
    params_t params;
  } item_t;
endpackage

/* File: pkg/dyn_stream_if.sv */
// sample stream with its parameter snapshot, between controller and buffer
// assumes both ends run on mclk
`timescale 1ns/1ps
interface dyn_stream_if;
  logic valid;
  logic ready;
  dyn_ctrl_pkg::item_t data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

/* File: hdl/field_guard.sv */
// one configuration field that refuses codes above its last defined one
// assumes load is a single-cycle write strobe
`timescale 1ns/1ps
module field_guard #(
  parameter int W = 2,
  parameter logic [W-1:0] MAX = '1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [W-1:0] code,
  output logic [W-1:0] value_q
);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      value_q <= RST;
    end else if (load && code <= MAX) begin
      value_q <= code;
    end
  end
endmodule

/* File: hdl/dyn_skid_buffer.sv */
// two-entry buffer: output register plus skid register
// assumes the sink may hold out_ready low for any time
`timescale 1ns/1ps
`include "dyn_ctrl_defs.svh"
module dyn_skid_buffer (
  input wire logic mclk,
  input wire logic resetn,
  dyn_stream_if.sink up,
  output logic out_valid,
  input wire logic out_ready,
  output dyn_ctrl_pkg::item_t out_item
);
  dyn_ctrl_pkg::item_t skid_q;
  logic skid_valid_q;
  logic ready_q;
  logic push;

  assign up.ready = ready_q;
  assign push = up.valid && ready_q;

  // ready is a flop of its own so the upstream port stays registered
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_item <= '0;
      out_valid <= 1'b0;
      skid_q <= '0;
      skid_valid_q <= 1'b0;
      ready_q <= 1'b1;
    end else if (!out_valid || out_ready) begin
      if (skid_valid_q) begin
        out_item <= skid_q;
        out_valid <= 1'b1;
        skid_valid_q <= 1'b0;
        ready_q <= 1'b1;
      end else begin
        if (push) begin
          out_item <= up.data;
        end
        out_valid <= push;
      end
    end else if (push) begin
      skid_q <= up.data;
      skid_valid_q <= 1'b1;
      ready_q <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_stall_hold: assert property ((out_valid && !out_ready) |=>
    $stable(out_item) && out_valid)
    else $error("buffered word changed while stalled");
  a_skid_refuse: assert property (skid_valid_q |-> !up.ready)
    else $error("buffer accepted a word while full");
endmodule

/* File: hdl/dynamics_controller.sv */
// dynamics controller settings and gain law for the second audio interface
// assumes a synchronous register port and a sample stream, both on mclk
`timescale 1ns/1ps
`include "dyn_ctrl_defs.svh"
module dynamics_controller (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [`DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DATA_W-1:0] reg_rdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [`SAMPLE_W-1:0] in_sample,
  output logic out_valid,
  input wire logic out_ready,
  output dyn_ctrl_pkg::item_t out_item
);
  logic wr_ctrl;
  logic wr_boost;
  logic wr_slope;
  logic wr_knee;
  logic wr_gknee;
  logic gate_enable_q;
  logic gate_knee_output_enable_q;
  logic [`BOOST_W-1:0] max_boost_gain;
  logic [`GMIN_W-1:0] gate_min_gain;
  logic [`EXP_W-1:0] gate_expansion_slope;
  logic [`QRT_W-1:0] quick_release_threshold;
  logic [`QRD_W-1:0] quick_release_decay;
  logic [`HI_W-1:0] upper_compress_slope;
  logic [`LO_W-1:0] lower_compress_slope;
  logic [`KIN_W-1:0] knee_input_level;
  logic [`KOUT_W-1:0] knee_output_level;
  logic [`GKIN_W-1:0] gate_knee_input_level;
  logic [`GKOUT_W-1:0] gate_knee_output_level;
  logic [`DATA_W-1:0] rdata_d;
  dyn_ctrl_pkg::params_t params;
  logic push;

  dyn_stream_if stream ();

  function automatic dyn_ctrl_pkg::qdb_t lin(input int base, input int step, input int n);
    return dyn_ctrl_pkg::qdb_t'(base + step * n);
  endfunction

  assign wr_ctrl = reg_wr && reg_addr == `OFS_CTRL;
  assign wr_boost = reg_wr && reg_addr == `OFS_BOOST;
  assign wr_slope = reg_wr && reg_addr == `OFS_GATE_SLOPE;
  assign wr_knee = reg_wr && reg_addr == `OFS_KNEE;
  assign wr_gknee = reg_wr && reg_addr == `OFS_GATE_KNEE;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gate_enable_q <= 1'b0;
      gate_knee_output_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      gate_enable_q <= reg_wdata[`GATE_EN_BIT];
      gate_knee_output_enable_q <= reg_wdata[`GKO_EN_BIT];
    end
  end

  field_guard #(.W(`BOOST_W), .RST(`BOOST_RST)) u_boost (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_boost),
    .code(reg_wdata[`BOOST_LSB +: `BOOST_W]),
    .value_q(max_boost_gain)
  );

  field_guard #(.W(`GMIN_W), .MAX(`GMIN_MAX)) u_gmin (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_slope),
    .code(reg_wdata[`GMIN_LSB +: `GMIN_W]),
    .value_q(gate_min_gain)
  );

  field_guard #(.W(`EXP_W)) u_exp (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_slope),
    .code(reg_wdata[`EXP_LSB +: `EXP_W]),
    .value_q(gate_expansion_slope)
  );

  field_guard #(.W(`QRT_W)) u_qrt (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_slope),
    .code(reg_wdata[`QRT_LSB +: `QRT_W]),
    .value_q(quick_release_threshold)
  );

  field_guard #(.W(`QRD_W), .MAX(`QRD_MAX)) u_qrd (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_slope),
    .code(reg_wdata[`QRD_LSB +: `QRD_W]),
    .value_q(quick_release_decay)
  );

  // upper slope, 110 and 111 refused
  field_guard #(.W(`HI_W), .MAX(`HI_MAX)) u_hi (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_slope),
    .code(reg_wdata[`HI_LSB +: `HI_W]),
    .value_q(upper_compress_slope)
  );

  // lower slope, 101 and 11x refused
  field_guard #(.W(`LO_W), .MAX(`LO_MAX)) u_lo (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_slope),
    .code(reg_wdata[`LO_LSB +: `LO_W]),
    .value_q(lower_compress_slope)
  );

  // knee input level, above 111100 refused
  field_guard #(.W(`KIN_W), .MAX(`KIN_MAX)) u_kin (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_knee),
    .code(reg_wdata[`KIN_LSB +: `KIN_W]),
    .value_q(knee_input_level)
  );

  field_guard #(.W(`KOUT_W), .MAX(`KOUT_MAX)) u_kout (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_knee),
    .code(reg_wdata[`KOUT_LSB +: `KOUT_W]),
    .value_q(knee_output_level)
  );

  field_guard #(.W(`GKIN_W)) u_gkin (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_gknee),
    .code(reg_wdata[`GKIN_LSB +: `GKIN_W]),
    .value_q(gate_knee_input_level)
  );

  field_guard #(.W(`GKOUT_W)) u_gkout (
    .mclk(mclk),
    .resetn(resetn),
    .load(wr_gknee),
    .code(reg_wdata[`GKOUT_LSB +: `GKOUT_W]),
    .value_q(gate_knee_output_level)
  );

  // read word assembly; unused bits and unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      `OFS_CTRL: begin
        rdata_d[`GATE_EN_BIT] = gate_enable_q;
        rdata_d[`GKO_EN_BIT] = gate_knee_output_enable_q;
      end
      `OFS_BOOST: begin
        rdata_d[`BOOST_LSB +: `BOOST_W] = max_boost_gain;
      end
      `OFS_GATE_SLOPE: begin
        rdata_d[`GMIN_LSB +: `GMIN_W] = gate_min_gain;
        rdata_d[`EXP_LSB +: `EXP_W] = gate_expansion_slope;
        rdata_d[`QRT_LSB +: `QRT_W] = quick_release_threshold;
        rdata_d[`QRD_LSB +: `QRD_W] = quick_release_decay;
        rdata_d[`HI_LSB +: `HI_W] = upper_compress_slope;
        rdata_d[`LO_LSB +: `LO_W] = lower_compress_slope;
      end
      `OFS_KNEE: begin
        rdata_d[`KIN_LSB +: `KIN_W] = knee_input_level;
        rdata_d[`KOUT_LSB +: `KOUT_W] = knee_output_level;
      end
      `OFS_GATE_KNEE: begin
        rdata_d[`GKIN_LSB +: `GKIN_W] = gate_knee_input_level;
        rdata_d[`GKOUT_LSB +: `GKOUT_W] = gate_knee_output_level;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= '0;
    end
  end

  // gain law decode; the guards keep reserved codes out, so each default decodes only the last defined code
  always_comb begin
    params = '0;
    case (max_boost_gain)
      2'h0: params.max_boost = lin(`BOOST_Q0, 0, 0);
      2'h1: params.max_boost = lin(`BOOST_Q1, 0, 0);
      2'h2: params.max_boost = lin(`BOOST_Q2, 0, 0);
      default: params.max_boost = lin(`BOOST_Q3, 0, 0);
    endcase
    params.gate_min = lin(`GMIN_BASE, `GMIN_STEP, int'(gate_min_gain));
    params.expand_shift = gate_expansion_slope;
    params.qr_thresh = lin(`QRT_BASE, `QRT_STEP, int'(quick_release_threshold));
    case (quick_release_decay)
      2'h0: params.qr_decay_us = `QRD_US_W'(`QRD_US0);
      2'h1: params.qr_decay_us = `QRD_US_W'(`QRD_US1);
      default: params.qr_decay_us = `QRD_US_W'(`QRD_US2);
    endcase
    // upper ratio 2^-code, last code is zero slope
    params.upper_zero = upper_compress_slope == `HI_ZERO;
    params.upper_shift = params.upper_zero ? '0 : upper_compress_slope;
    // lower ratio 2^-code, last code is zero slope
    params.lower_zero = lower_compress_slope == `LO_ZERO;
    params.lower_shift = params.lower_zero ? '0 : lower_compress_slope;
    params.knee_in = lin(0, `KNEE_STEP, int'(knee_input_level));
    params.knee_out = lin(0, `KNEE_STEP, int'(knee_output_level));
    params.gate_knee_in = lin(`GKIN_BASE, `GKNEE_STEP, int'(gate_knee_input_level));
    params.gate_knee_out = lin(`GKOUT_BASE, `GKNEE_STEP, int'(gate_knee_output_level));
    // gate knee use flags follow their enables; the levels themselves pass unmasked
    params.gate_knee_in_use = gate_enable_q;
    params.gate_knee_out_use = gate_knee_output_enable_q;
  end

  // settings travel with the sample they were captured on
  assign stream.valid = in_valid;
  assign stream.data = '{sample: in_sample, params: params};
  assign in_ready = stream.ready;
  assign push = in_valid && in_ready;

  dyn_skid_buffer u_buf (
    .mclk(mclk),
    .resetn(resetn),
    .up(stream.sink),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_item(out_item)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_boost_top: assert property ((push && max_boost_gain == 2'h3) |->
    stream.data.params.max_boost == 10'sd144)
    else $error("boost code 11 not 36dB");
  a_boost_low: assert property ((push && max_boost_gain == 2'h0) |->
    stream.data.params.max_boost == 10'sd48)
    else $error("boost code 00 not 12dB");
  a_gate_floor: assert property (push |->
    (params.gate_min >= -10'sd144 && params.gate_min <= 10'sd144))
    else $error("gate floor outside -36..+36dB");
  a_floor_ends: assert property ((push && gate_min_gain == 4'hc) |->
    params.gate_min == 10'sd144)
    else $error("gate floor code 1100 not +36dB");
  a_expand_slope: assert property (push |-> params.expand_shift == gate_expansion_slope)
    else $error("expansion ratio wrong");
  a_qr_thresh: assert property ((push && quick_release_threshold == 2'h3) |->
    params.qr_thresh == 10'sd120)
    else $error("threshold code 11 not 30dB");
  a_qr_decay: assert property (push |->
    params.qr_decay_us inside {13'd725, 13'd1450, 13'd5800})
    else $error("decay rate off table");
  a_decay_slow: assert property ((push && quick_release_decay == 2'h2) |->
    params.qr_decay_us == 13'd5800)
    else $error("decay code 10 not 5.8ms");
  a_upper_zero: assert property (params.upper_zero |-> upper_compress_slope == 3'h5)
    else $error("upper zero slope on wrong code");
  a_upper_step: assert property ((push && upper_compress_slope == 3'h4) |->
    !params.upper_zero && params.upper_shift == 3'h4)
    else $error("upper code 100 not 1/16");
  a_lower_zero: assert property (params.lower_zero |-> lower_compress_slope == 3'h4)
    else $error("lower zero slope on wrong code");
  a_lower_step: assert property ((push && lower_compress_slope == 3'h3) |->
    !params.lower_zero && params.lower_shift == 3'h3)
    else $error("lower code 011 not 1/8");
  a_knee_span: assert property (push |->
    params.knee_in >= -10'sd180 && params.knee_out >= -10'sd90)
    else $error("knee beyond -45/-22.5dB");
  a_knee_top: assert property ((push && knee_input_level == 6'h3c) |->
    params.knee_in == -10'sd180)
    else $error("knee code 111100 not -45dB");
  a_gknee_span: assert property (push |->
    params.gate_knee_in <= -10'sd144 && params.gate_knee_in >= -10'sd330)
    else $error("gate knee input out of span");
  a_gknee_out: assert property (push |->
    params.gate_knee_out <= -10'sd120 && params.gate_knee_out >= -10'sd306)
    else $error("gate knee output out of span");
  a_gknee_use: assert property (push |->
    stream.data.params.gate_knee_in_use == gate_enable_q &&
    stream.data.params.gate_knee_out_use == gate_knee_output_enable_q)
    else $error("gate knee enables not followed");
  a_gknee_follow: assert property (wr_ctrl |=>
    params.gate_knee_out_use == $past(reg_wdata[`GKO_EN_BIT]))
    else $error("gate knee output enable not written");
  a_gate_enable: assert property (wr_ctrl |=>
    gate_enable_q == $past(reg_wdata[`GATE_EN_BIT]))
    else $error("gate enable not written");
  a_reserved_hold: assert property ((wr_slope && reg_wdata[`QRD_LSB +: `QRD_W] == 2'h3) |=>
    $stable(quick_release_decay))
    else $error("reserved decay code stored");
  a_reserved_other: assert property ((wr_slope && reg_wdata[`GMIN_LSB +: `GMIN_W] > 4'hc) |=>
    gate_expansion_slope == $past(reg_wdata[`EXP_LSB +: `EXP_W]))
    else $error("reserved floor disturbed another field");
  a_floor_reserved: assert property ((wr_slope && reg_wdata[`GMIN_LSB +: `GMIN_W] > `GMIN_MAX) |=>
    $stable(gate_min_gain))
    else $error("reserved floor code stored");
  a_upper_reserved: assert property ((wr_slope && reg_wdata[`HI_LSB +: `HI_W] > `HI_MAX) |=>
    $stable(upper_compress_slope))
    else $error("reserved upper slope stored");
  a_lower_reserved: assert property ((wr_slope && reg_wdata[`LO_LSB +: `LO_W] > `LO_MAX) |=>
    $stable(lower_compress_slope))
    else $error("reserved lower slope stored");
  a_knee_reserved: assert property ((wr_knee && reg_wdata[`KIN_LSB +: `KIN_W] > `KIN_MAX) |=>
    $stable(knee_input_level))
    else $error("reserved knee input stored");

  // a read answers in the next cycle only, then the port falls back to zero
  sequence s_boost_read;
    reg_rd && reg_addr == `OFS_BOOST;
  endsequence
  sequence s_boost_answer;
    reg_rdata[`BOOST_LSB +: `BOOST_W] == $past(max_boost_gain)
    ##1 (reg_rdata == '0 || $past(reg_rd));
  endsequence
  a_read_late: assert property (s_boost_read |=> s_boost_answer)
    else $error("read data timing wrong");
endmodule

/* File: verification/tb_top.sv */
// self-checking bench: register port and sample stream of the dynamics controller
// assumes the defs header is on the include path and the package is compiled first
`timescale 1ns/1ps
`include "dyn_ctrl_defs.svh"
module tb_top;
  logic mclk;
  logic resetn;
  logic [`ADDR_W-1:0] reg_addr;
  logic [`DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [`DATA_W-1:0] reg_rdata;
  logic in_valid;
  logic in_ready;
  logic [`SAMPLE_W-1:0] in_sample;
  logic out_valid;
  logic out_ready;
  dyn_ctrl_pkg::item_t out_item;
  dyn_ctrl_pkg::item_t it;
  dyn_ctrl_pkg::params_t p;
  int n_errors;
  int n_compared;
  int boost_q[4] = '{`BOOST_Q0, `BOOST_Q1, `BOOST_Q2, `BOOST_Q3};
  int decay_us[3] = '{`QRD_US0, `QRD_US1, `QRD_US2};

  dynamics_controller u_dut (
    .mclk(mclk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_sample(in_sample),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_item(out_item)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so look mid-cycle
  task automatic rd_check(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] e,
                          input string what);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    check(what, reg_rdata, e);
  endtask

  task automatic push(input logic [`SAMPLE_W-1:0] s);
    int k;
    @(posedge mclk);
    in_valid <= 1'b1;
    in_sample <= s;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (in_ready !== 1'b1 && k < 100);
    if (k >= 100) n_errors++;
    @(posedge mclk);
    in_valid <= 1'b0;
  endtask

  task automatic pop();
    int k;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while ((out_valid !== 1'b1 || out_ready !== 1'b1) && k < 100);
    if (k >= 100) n_errors++;
    it = out_item;
    @(posedge mclk);
  endtask

  task automatic get(input logic [`SAMPLE_W-1:0] s);
    push(s);
    pop();
    check("sample", it.sample, s);
    p = it.params;
  endtask

  task automatic t_reset();
    rd_check(`OFS_CTRL, 16'h0000, "ctrl");
    rd_check(`OFS_BOOST, 16'h0001, "boost");
    rd_check(`OFS_GATE_SLOPE, 16'h0000, "gate_slope");
    rd_check(`OFS_KNEE, 16'h0000, "knee");
    rd_check(`OFS_GATE_KNEE, 16'h0000, "gate_knee");
    rd_check(12'h545, 16'h0000, "unmapped");
    get(24'h000011);
    check("boost_q", p.max_boost, `BOOST_Q1);
    check("gate_min_q", p.gate_min, `GMIN_BASE);
    check("qr_thresh_q", p.qr_thresh, `QRT_BASE);
    check("decay_us", p.qr_decay_us, `QRD_US0);
    check("gk_use", {p.gate_knee_in_use, p.gate_knee_out_use}, 0);
  endtask

  task automatic t_boost();
    for (int i = 0; i < 4; i++) begin
      reg_write(`OFS_BOOST, 16'(i));
      rd_check(`OFS_BOOST, 16'(i), "boost_rb");
      get(24'(i));
      check("boost_q", p.max_boost, boost_q[i]);
    end
  endtask

  task automatic t_slopes();
    logic [`DATA_W-1:0] w;
    for (int i = 0; i < 13; i++) begin
      w = {4'(i), 2'(i % 4), 2'(i % 4), 2'(i % 3), 3'(i % 6), 3'(i % 5)};
      reg_write(`OFS_GATE_SLOPE, w);
      rd_check(`OFS_GATE_SLOPE, w, "slope_rb");
      get(24'(i + 16));
      check("gate_min_q", p.gate_min, `GMIN_BASE + `GMIN_STEP * i);
      check("expand", p.expand_shift, i % 4);
      check("qr_thresh_q", p.qr_thresh, `QRT_BASE + `QRT_STEP * (i % 4));
      check("decay_us", p.qr_decay_us, decay_us[i % 3]);
      check("upper", (i % 6 == 5) ? p.upper_zero : {p.upper_zero, p.upper_shift},
            (i % 6 == 5) ? 1 : i % 6);
      check("lower", (i % 5 == 4) ? p.lower_zero : {p.lower_zero, p.lower_shift},
            (i % 5 == 4) ? 1 : i % 5);
    end
  endtask

  task automatic t_reserved();
    reg_write(`OFS_GATE_SLOPE, {4'h3, 2'h0, 2'h0, 2'h1, 3'h2, 3'h1});
    reg_write(`OFS_GATE_SLOPE, {4'hd, 2'h3, 2'h1, 2'h3, 3'h6, 3'h5});
    rd_check(`OFS_GATE_SLOPE, {4'h3, 2'h3, 2'h1, 2'h1, 3'h2, 3'h1}, "rsv1");
    reg_write(`OFS_GATE_SLOPE, {4'hf, 2'h2, 2'h3, 2'h3, 3'h7, 3'h7});
    rd_check(`OFS_GATE_SLOPE, {4'h3, 2'h2, 2'h3, 2'h1, 3'h2, 3'h1}, "rsv2");
    reg_write(`OFS_KNEE, {5'h00, 6'h10, 5'h08});
    reg_write(`OFS_KNEE, {5'h00, 6'h3d, 5'h1f});
    rd_check(`OFS_KNEE, {5'h00, 6'h10, 5'h08}, "rsv_knee");
    reg_write(`OFS_KNEE, {5'h00, 6'h3f, 5'h02});
    rd_check(`OFS_KNEE, {5'h00, 6'h10, 5'h02}, "rsv_knee2");
    reg_write(12'h545, 16'hffff);
    rd_check(`OFS_BOOST, 16'h0003, "boost_kept");
    get(24'h000077);
    check("gate_min_q", p.gate_min, `GMIN_BASE + 3 * `GMIN_STEP);
    check("knee_in_q", p.knee_in, 16 * `KNEE_STEP);
  endtask

  task automatic t_knee();
    reg_write(`OFS_KNEE, {5'h00, 6'h3c, 5'h1e});
    reg_write(`OFS_GATE_KNEE, {6'h00, 5'h1f, 5'h1f});
    reg_write(`OFS_CTRL, 16'hffff);
    rd_check(`OFS_CTRL, 16'h0120, "ctrl_rb");
    get(24'h000033);
    check("knee_in_q", p.knee_in, 60 * `KNEE_STEP);
    check("knee_out_q", p.knee_out, 30 * `KNEE_STEP);
    check("gk_in_q", p.gate_knee_in, `GKIN_BASE + 31 * `GKNEE_STEP);
    check("gk_out_q", p.gate_knee_out, `GKOUT_BASE + 31 * `GKNEE_STEP);
    for (int c = 0; c < 4; c++) begin
      reg_write(`OFS_CTRL, {7'h00, 1'(c >> 1), 2'h0, 1'(c), 5'h00});
      get(24'(c + 64));
      check("gk_use", {p.gate_knee_in_use, p.gate_knee_out_use}, c);
    end
  endtask

  // snapshot before the edge, stall loses nothing
  task automatic t_stream();
    reg_write(`OFS_BOOST, 16'h0000);
    @(posedge mclk);
    out_ready <= 1'b0;
    in_valid <= 1'b1;
    in_sample <= 24'h0000a1;
    reg_wr <= 1'b1;
    reg_addr <= `OFS_BOOST;
    reg_wdata <= 16'h0003;
    @(posedge mclk);
    reg_wr <= 1'b0;
    in_sample <= 24'h0000b2;
    @(posedge mclk);
    in_valid <= 1'b0;
    repeat (3) @(negedge mclk);
    check("in_ready_full", in_ready, 1'b0);
    check("held_sample", out_item.sample, 24'h0000a1);
    @(posedge mclk);
    out_ready <= 1'b1;
    pop();
    check("first", {it.sample, it.params.max_boost}, {24'h0000a1, 10'(`BOOST_Q0)});
    pop();
    check("second", {it.sample, it.params.max_boost}, {24'h0000b2, 10'(`BOOST_Q3)});
    @(negedge mclk);
    check("drained", {out_valid, in_ready}, 2'b01);
  endtask

  task automatic t_rereset();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd_check(`OFS_BOOST, 16'h0001, "boost_rst");
    rd_check(`OFS_CTRL, 16'h0000, "ctrl_rst");
  endtask

  initial begin
    resetn = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    in_valid = 1'b0;
    in_sample = '0;
    out_ready = 1'b1;
    n_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_boost();
    t_slopes();
    t_reserved();
    t_knee();
    t_stream();
    t_rereset();
    tally_and_finish();
  end

  // the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end
endmodule
